/* File: logic/power_sequencer.sv */
// Startup and shutdown sequencer with APB register file
`timescale 1ns/1ps
`default_nettype none
`include "power_sequencer_consts.svh"

module power_sequencer #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES_DEF
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic POWER_REQUEST_I,
  input wire logic SUPPLY_HOLD_I,
  input wire logic THIRD_LDO_ENABLE_I,
  input wire logic SECOND_BUCK_ENABLE_I,
  input wire logic BUCK1_LEVEL_SELECT_I,
  input wire logic DEFAULT_SET_SELECT_I,
  input wire logic TOPOLOGY_SELECT_I,
  input wire logic OVER_TEMP_I,
  output logic [7:0] REG_EN_O,
  output logic RESET_N_O,
  output logic [7:0] BUCK1_VOLT_O,
  output logic [7:0] BUCK2_VOLT_O,
  output logic IRQ_O
);

  // ========================================================
  // Pin synchronisers
  logic [7:0] sync1_reg;
  power_sequencer_pkg::pins_t pin;
  power_sequencer_pkg::pins_t prev_reg;
  logic [1:0] init_reg;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync1_reg <= 8'h00;
      pin <= '0;
      prev_reg <= '0;
      init_reg <= 2'h0;
    end else begin
      sync1_reg <= {POWER_REQUEST_I, SUPPLY_HOLD_I, THIRD_LDO_ENABLE_I, SECOND_BUCK_ENABLE_I,
                    BUCK1_LEVEL_SELECT_I, DEFAULT_SET_SELECT_I, TOPOLOGY_SELECT_I, OVER_TEMP_I};
      pin <= sync1_reg;
      prev_reg <= pin;
      init_reg <= {init_reg[0], 1'b1};
    end
  end

  // ========================================================
  // Slot compare per output
  logic [31:0] slot_reg;
  logic [3:0] step_reg;
  logic [`NUM_OUT-1:0] hit_up;
  logic [`NUM_OUT-1:0] hit_dn;
  logic [`NUM_OUT-1:0] zero_mask;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_OUT; gi++) begin : g_slot
      assign hit_up[gi] = slot_reg[4*gi+3:4*gi] == step_reg + 4'h1;
      assign hit_dn[gi] = slot_reg[4*gi+3:4*gi] == step_reg;
      assign zero_mask[gi] = slot_reg[4*gi+3:4*gi] == 4'h0;
    end
  endgenerate

  // ========================================================
  // Sequencer
  power_sequencer_pkg::state_t state_reg, state_next;
  logic [23:0] tmr_reg, tmr_next;
  logic [3:0] step_next;
  logic [7:0] en_reg, en_next;
  logic rst_n_reg, rst_n_next;
  logic arm_reg, arm_next;
  logic [1:0] pin_on_reg, pin_on_next;
  logic default_set_select_pin_reg, default_set_select_pin_next;
  logic topo_reg, topo_next;
  logic topo_done_reg, topo_done_next;
  logic load_def;
  logic [2:0] ev;
  logic host_wr;
  logic tick;
  logic [7:0] pin_mask;

  // Step tick only meaningful while stepping
  assign tick = tmr_reg == 24'(`STEP_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg + 24'h1;
    step_next = step_reg;
    en_next = en_reg;
    rst_n_next = rst_n_reg;
    arm_next = arm_reg;
    pin_on_next = pin_on_reg;
    default_set_select_pin_next = default_set_select_pin_reg;
    topo_next = topo_reg;
    topo_done_next = topo_done_reg;
    load_def = 1'b0;
    ev = 3'h0;
    pin_mask = 8'h00;
    pin_mask[`IDX_LDO3] = pin_on_reg[0];
    pin_mask[`IDX_BUCK2] = pin_on_reg[1];
    if (init_reg == 2'b11 && !topo_done_reg) begin
      topo_next = pin.topo;
      topo_done_next = 1'b1;
    end
    case (state_reg)
      power_sequencer_pkg::S_OFF: begin
        en_next = 8'h00;
        rst_n_next = 1'b0;
        tmr_next = 24'h0;
        if (!pin.req) begin
          arm_next = 1'b1;
        end
        // Edge start in module setup, re-armed by a thermal trip
        if (topo_done_reg && !pin.ot && pin.req && arm_reg) begin
          default_set_select_pin_next = pin.default_set_select_pin;
          arm_next = 1'b0;
          pin_on_next = {pin.b2 & ~topo_reg, pin.ldo3};
          state_next = topo_reg ? power_sequencer_pkg::S_DEB : power_sequencer_pkg::S_BIAS;
        end
      end
      power_sequencer_pkg::S_DEB: begin
        if (!pin.req) begin
          state_next = power_sequencer_pkg::S_OFF;
          arm_next = 1'b1;
        end else if (tmr_reg == 24'(DEBOUNCE_CYCLES - 1)) begin
          load_def = 1'b1;
          tmr_next = 24'h0;
          step_next = 4'h0;
          state_next = power_sequencer_pkg::S_UP;
        end
      end
      power_sequencer_pkg::S_BIAS: begin
        if (tmr_reg == 24'(`BIAS_CYCLES - 1)) begin
          tmr_next = 24'h0;
          step_next = 4'h0;
          state_next = power_sequencer_pkg::S_UP;
        end
      end
      power_sequencer_pkg::S_UP: begin
        if (tick) begin
          tmr_next = 24'h0;
          step_next = step_reg + 4'h1;
          en_next = en_reg | hit_up;
          if (step_reg + 4'h1 == `PIN_STEP) begin
            en_next = en_reg | hit_up | pin_mask;
          end
          if (step_reg + 4'h1 == `LAST_STEP) begin
            state_next = power_sequencer_pkg::S_IDLE;
            rst_n_next = 1'b1;
            ev[`EV_UP_DONE] = 1'b1;
          end
        end
      end
      power_sequencer_pkg::S_IDLE: begin
        if (host_wr) begin
          en_next = PWDATA_I[7:0];
        end
        if (pin.ldo3 != prev_reg.ldo3) begin
          en_next[`IDX_LDO3] = pin.ldo3;
        end
        if (!topo_reg && pin.b2 != prev_reg.b2) begin
          en_next[`IDX_BUCK2] = pin.b2;
        end
        tmr_next = 24'h0;
        if (topo_reg && !pin.req && !pin.hold) begin
          tmr_next = tmr_reg + 24'h1;
        end
        if ((topo_reg && !pin.req && !pin.hold && tmr_reg == 24'(DEBOUNCE_CYCLES - 1)) ||
            (!topo_reg && prev_reg.req && !pin.req)) begin
          state_next = power_sequencer_pkg::S_DOWN;
          rst_n_next = 1'b0;
          en_next = en_reg & ~zero_mask;
          step_next = `LAST_STEP;
          tmr_next = 24'h0;
        end
      end
      power_sequencer_pkg::S_DOWN: begin
        if (tick) begin
          tmr_next = 24'h0;
          en_next = en_reg & ~hit_dn;
          step_next = step_reg - 4'h1;
          if (step_reg == 4'h1) begin
            state_next = power_sequencer_pkg::S_OFF;
            load_def = 1'b1;
            ev[`EV_DOWN_DONE] = 1'b1;
          end
        end
      end
      default: begin
        state_next = power_sequencer_pkg::S_OFF;
      end
    endcase
    if (state_reg != power_sequencer_pkg::S_OFF && pin.ot) begin
      state_next = power_sequencer_pkg::S_OFF;
      en_next = 8'h00;
      rst_n_next = 1'b0;
      arm_next = 1'b1;
      ev[`EV_THERMAL] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg <= power_sequencer_pkg::S_OFF;
      tmr_reg <= 24'h0;
      step_reg <= 4'h0;
      en_reg <= 8'h00;
      rst_n_reg <= 1'b0;
      arm_reg <= 1'b1;
      pin_on_reg <= 2'h0;
      default_set_select_pin_reg <= 1'b0;
      topo_reg <= 1'b0;
      topo_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      step_reg <= step_next;
      en_reg <= en_next;
      rst_n_reg <= rst_n_next;
      arm_reg <= arm_next;
      pin_on_reg <= pin_on_next;
      default_set_select_pin_reg <= default_set_select_pin_next;
      topo_reg <= topo_next;
      topo_done_reg <= topo_done_next;
    end
  end

  assign REG_EN_O = en_reg;
  assign RESET_N_O = rst_n_reg;

  // ========================================================
  // APB register file
  logic [31:0] slot_next, volt_reg, volt_next, prdata_next, rdata;
  logic [1:0] lvl_reg, lvl_next;
  logic [2:0] stat_reg, stat_next, mask_reg, mask_next;
  logic pready_next, pslverr_next, irq_next, err, wr;
  logic [7:0] b1_next, b2_next;

  // Access completes one cycle into the access phase
  always_comb begin
    wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
    slot_next = slot_reg;
    volt_next = volt_reg;
    lvl_next = lvl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg | ev;
    rdata = 32'h0;
    err = 1'b0;
    host_wr = 1'b0;
    if (PADDR_I == `ADDR_ENABLE) begin
      rdata = {24'h0, en_reg};
      host_wr = wr && state_reg == power_sequencer_pkg::S_IDLE;
    end else if (PADDR_I == `ADDR_SLOT) begin
      rdata = slot_reg;
      slot_next = wr ? PWDATA_I : slot_reg;
    end else if (PADDR_I == `ADDR_VOLT) begin
      rdata = volt_reg;
      volt_next = wr ? PWDATA_I : volt_reg;
    end else if (PADDR_I == `ADDR_LEVEL) begin
      rdata = {30'h0, lvl_reg};
      lvl_next = wr ? PWDATA_I[1:0] : lvl_reg;
    end else if (PADDR_I == `ADDR_STATUS) begin
      rdata = {23'h0, topo_reg, default_set_select_pin_reg, state_reg, step_reg};
    end else if (PADDR_I == `ADDR_IRQ_STAT) begin
      rdata = {29'h0, stat_reg};
      // New events win over a clear in the same cycle
      stat_next = wr ? ((stat_reg & ~PWDATA_I[2:0]) | ev) : (stat_reg | ev);
    end else if (PADDR_I == `ADDR_IRQ_MASK) begin
      rdata = {29'h0, mask_reg};
      mask_next = wr ? PWDATA_I[2:0] : mask_reg;
    end else begin
      err = 1'b1;
    end
    if (load_def) begin
      slot_next = default_set_select_pin_reg ? `SLOT_DEF_B : `SLOT_DEF_A;
      volt_next = default_set_select_pin_reg ? `VOLT_DEF_B : `VOLT_DEF_A;
      lvl_next = `LEVEL_DEF;
    end
    pready_next = PSEL_I & PENABLE_I & ~PREADY_O;
    prdata_next = pready_next ? rdata : 32'h0;
    pslverr_next = pready_next & err;
    b1_next = (lvl_reg[0] | pin.buck1_level_select_pin) ? volt_reg[15:8] : volt_reg[7:0];
    b2_next = lvl_reg[1] ? volt_reg[31:24] : volt_reg[23:16];
    irq_next = |(stat_reg & mask_reg);
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      slot_reg <= `SLOT_DEF_A;
      volt_reg <= `VOLT_DEF_A;
      lvl_reg <= `LEVEL_DEF;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0;
      PSLVERR_O <= 1'b0;
      BUCK1_VOLT_O <= 8'h00;
      BUCK2_VOLT_O <= 8'h00;
      IRQ_O <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      volt_reg <= volt_next;
      lvl_reg <= lvl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      PREADY_O <= pready_next;
      PRDATA_O <= prdata_next;
      PSLVERR_O <= pslverr_next;
      BUCK1_VOLT_O <= b1_next;
      BUCK2_VOLT_O <= b2_next;
      IRQ_O <= irq_next;
    end
  end

  // ========================================================
  // Assertions
  logic b1_sel;
  assign b1_sel = lvl_reg[0] | pin.buck1_level_select_pin;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  property p_step_adv;
    (state_reg == power_sequencer_pkg::S_UP && tick && !pin.ot) |=>
      step_reg == $past(step_reg) + 4'h1 && (REG_EN_O & $past(hit_up)) == $past(hit_up);
  endproperty
  a_step_adv: assert property (p_step_adv) else $error("Step slot not enabled");

  property p_step_hold;
    (state_reg == power_sequencer_pkg::S_UP && !tick && !pin.ot) |=> $stable(step_reg) && $stable(REG_EN_O);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("Step moved between ticks");

  property p_reverse;
    (state_reg == power_sequencer_pkg::S_DOWN && tick && !pin.ot) |=>
      (REG_EN_O & $past(hit_dn)) == 8'h00 && step_reg == $past(step_reg) - 4'h1;
  endproperty
  a_reverse: assert property (p_reverse) else $error("Shutdown step not disabled");

  property p_down_start;
    (state_reg == power_sequencer_pkg::S_IDLE && state_next == power_sequencer_pkg::S_DOWN) |=>
      !RESET_N_O && (REG_EN_O & $past(zero_mask)) == 8'h00;
  endproperty
  a_down_start: assert property (p_down_start) else $error("Shutdown start wrong");

  property p_thermal;
    (pin.ot && state_reg != power_sequencer_pkg::S_OFF) |=> REG_EN_O == 8'h00 ##1 REG_EN_O == 8'h00;
  endproperty
  a_thermal: assert property (p_thermal) else $error("Thermal shutdown missed");

  property p_debounce;
    (state_reg == power_sequencer_pkg::S_DEB && state_next == power_sequencer_pkg::S_UP) |->
      tmr_reg == 24'(DEBOUNCE_CYCLES - 1);
  endproperty
  a_debounce: assert property (p_debounce) else $error("Debounce too short");

  property p_bias;
    (state_reg == power_sequencer_pkg::S_BIAS && state_next == power_sequencer_pkg::S_UP) |->
      tmr_reg == 24'(`BIAS_CYCLES - 1);
  endproperty
  a_bias: assert property (p_bias) else $error("Bias wait wrong");

  property p_buck1;
    $past(RESET_N_I) && $past(b1_sel) |-> BUCK1_VOLT_O == $past(volt_reg[15:8]);
  endproperty
  a_buck1: assert property (p_buck1) else $error("Buck one level wrong");

  property p_buck2;
    $past(RESET_N_I) && !$past(lvl_reg[1]) |-> BUCK2_VOLT_O == $past(volt_reg[23:16]);
  endproperty
  a_buck2: assert property (p_buck2) else $error("Buck two level wrong");

  property p_defaults;
    (state_reg == power_sequencer_pkg::S_DOWN && state_next == power_sequencer_pkg::S_OFF) |=>
      slot_reg == ($past(default_set_select_pin_reg) ? `SLOT_DEF_B : `SLOT_DEF_A);
  endproperty
  a_defaults: assert property (p_defaults) else $error("Defaults not restored");

endmodule
`default_nettype wire

/* File: logic/power_sequencer_consts.svh */
// Offsets, default values and timing counts of the power sequencer
`ifndef POWER_SEQUENCER_CONSTS_SVH
`define POWER_SEQUENCER_CONSTS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define STEP_TIME_NS 64000
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIAS_TIME_NS 75000
`define BIAS_CYCLES ((`BIAS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_TIME_MS 30
`define DEBOUNCE_CYCLES_DEF ((`DEBOUNCE_TIME_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Register offsets
`define ADDR_ENABLE 8'h00
`define ADDR_SLOT 8'h04
`define ADDR_VOLT 8'h08
`define ADDR_LEVEL 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_IRQ_STAT 8'h14
`define ADDR_IRQ_MASK 8'h18

// ==========================================================
// Defaults, one set per default-set pin level
`define SLOT_DEF_A 32'h07504321
`define SLOT_DEF_B 32'h08060421
`define VOLT_DEF_A 32'h30281810
`define VOLT_DEF_B 32'h34201c14
`define LEVEL_DEF 2'h0

// ==========================================================
// Outputs, steps, events
`define NUM_OUT 8
`define IDX_BUCK2 1
`define IDX_LDO3 4
`define PIN_STEP 4'h6
`define LAST_STEP 4'hf
`define EV_UP_DONE 0
`define EV_DOWN_DONE 1
`define EV_THERMAL 2

`endif

/* File: logic/power_sequencer_pkg.sv */
// Types of the power sequencer
`default_nettype none
package power_sequencer_pkg;

  typedef enum logic [2:0] {
    S_OFF = 3'b000,
    S_DEB = 3'b001,
    S_BIAS = 3'b010,
    S_UP = 3'b011,
    S_IDLE = 3'b100,
    S_DOWN = 3'b101
  } state_t;

  typedef struct packed {
    logic req;
    logic hold;
    logic ldo3;
    logic b2;
    logic buck1_level_select_pin;
    logic default_set_select_pin;
    logic topo;
    logic ot;
  } pins_t;

endpackage
`default_nettype wire

/* File: tb/host_pins.sv */
// Host-side model driving the sequencer's request and control pins
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic on_i,
  input wire logic ldo3_i,
  input wire logic dvs_i,
  input wire logic hot_i,
  input wire logic topo_i,
  output var power_sequencer_pkg::pins_t pins_o
);
  // ==========================================
  // Pin drive
  // Hold drops one cycle before the request, so both are low together
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Topology must already stand during reset, it is latched right after release
      pins_o <= '{topo: topo_i, default: 1'b0};
    end else begin
      pins_o.hold <= on_i;
      pins_o.req <= on_i | (pins_o.hold & pins_o.req);
      pins_o.ldo3 <= ldo3_i;
      pins_o.b2 <= 1'b0;
      pins_o.buck1_level_select_pin <= dvs_i;
      pins_o.default_set_select_pin <= 1'b0;
      pins_o.topo <= topo_i;
      pins_o.ot <= hot_i;
    end
  end
endmodule
`default_nettype wire

/* File: tb/power_sequencer_tb.sv */
// Self-checking bench of the power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "power_sequencer_consts.svh"
module power_sequencer_tb;
  localparam int DEB = 20;
  localparam int STEP = `STEP_CYCLES;
  localparam int CYC_MAX = 120000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic on = 1'b0;
  logic ldo3 = 1'b0;
  logic buck1_level_select_pin = 1'b0;
  logic hot = 1'b0;
  logic topo = 1'b1;
  power_sequencer_pkg::pins_t pins;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] en;
  logic rst_out;
  logic [7:0] v1;
  logic [7:0] v2;
  logic irq;
  logic [31:0] rd;
  logic [31:0] volt;
  logic er;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int t0;

  host_pins host_pins_i (.clk_i(clk), .rst_n_i(rst_n), .on_i(on), .ldo3_i(ldo3), .dvs_i(buck1_level_select_pin),
    .hot_i(hot), .topo_i(topo), .pins_o(pins));

  power_sequencer #(.DEBOUNCE_CYCLES(DEB)) power_sequencer_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .POWER_REQUEST_I(pins.req),
    .SUPPLY_HOLD_I(pins.hold), .THIRD_LDO_ENABLE_I(pins.ldo3), .SECOND_BUCK_ENABLE_I(pins.b2),
    .BUCK1_LEVEL_SELECT_I(pins.buck1_level_select_pin), .DEFAULT_SET_SELECT_I(pins.default_set_select_pin),
    .TOPOLOGY_SELECT_I(pins.topo), .OVER_TEMP_I(pins.ot), .REG_EN_O(en), .RESET_N_O(rst_out),
    .BUCK1_VOLT_O(v1), .BUCK2_VOLT_O(v2), .IRQ_O(irq));

  // ==========================================
  // Clock, cycle count, hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      bad_count++;
      test_done();
    end
  end

  // ==========================================
  // Helpers
  task test_done;
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Master waits for ready with no assumed latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task at(input int t);
    while (cyc < t) begin
      @(posedge clk);
      #1;
    end
  endtask

  task wait_en(input int b, input logic lvl, input int lim);
    int n;
    n = 0;
    while (en[b] !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(en[b]), 32'(lvl));
  endtask

  function automatic logic [7:0] up_exp(input logic [31:0] s, input int k, input logic pin);
    logic [7:0] e;
    for (int i = 0; i < `NUM_OUT; i++) e[i] = s[4*i+:4] != 4'h0 && s[4*i+:4] <= k;
    if (pin && k >= `PIN_STEP) e[`IDX_LDO3] = 1'b1;
    return e;
  endfunction

  // Pin-driven and slot-zero outputs left out of the downward walk
  function automatic logic [7:0] dn_exp(input logic [31:0] s, input int k);
    logic [7:0] e;
    for (int i = 0; i < `NUM_OUT; i++) e[i] = s[4*i+:4] != 4'h0 && s[4*i+:4] < k;
    return e & 8'h6f;
  endfunction

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(74));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    ldo3 <= 1'b1;
    on <= 1'b1;
    t0 = cyc;
    @(posedge clk);
    #1;
    wait_en(0, 1'b1, DEB + STEP + 100);
    check(32'(cyc - t0 >= DEB), 32'h1);
    t0 = cyc;
    for (int k = 1; k <= 15; k++) begin
      at(t0 + STEP * (k - 1));
      check(32'(en), 32'(up_exp(`SLOT_DEF_A, k, 1'b1)));
      check(32'(rst_out), 32'(k == 15));
      if (k == 3) apb(1'b1, `ADDR_ENABLE, 32'hff);
      at(t0 + STEP * k - 1);
      check(32'(en), 32'(up_exp(`SLOT_DEF_A, k, 1'b1)));
    end
    at(t0 + STEP * 15 + 10);
    check(32'(rst_out), 32'h1);
    apb(1'b0, `ADDR_SLOT, 32'h0);
    check(rd, `SLOT_DEF_A);
    apb(1'b0, 8'h1c, 32'h0);
    check(32'(er), 32'h1);
    check(rd, 32'h0);
    apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
    check(rd & 32'h7, 32'h1);
    check(32'(irq), 32'h0);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h3);
    repeat (3) @(posedge clk);
    #1;
    check(32'(irq), 32'h1);
    apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    check(32'(irq), 32'h0);
    volt = $urandom;
    apb(1'b1, `ADDR_VOLT, volt);
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      buck1_level_select_pin <= m[2];
      apb(1'b1, `ADDR_LEVEL, 32'(m[1:0]));
      repeat (6) @(posedge clk);
      #1;
      check(32'(v1), 32'((m[0] | m[2]) ? volt[15:8] : volt[7:0]));
      check(32'(v2), 32'(m[1] ? volt[31:24] : volt[23:16]));
    end
    apb(1'b1, `ADDR_ENABLE, 32'(up_exp(`SLOT_DEF_A, 15, 1'b1) | 8'h80));
    repeat (3) @(posedge clk);
    #1;
    check(32'(en), 32'(up_exp(`SLOT_DEF_A, 15, 1'b1) | 8'h80));
    // Shutdown
    @(posedge clk);
    on <= 1'b0;
    t0 = cyc;
    at(t0 + 2);
    while (rst_out !== 1'b0 && cyc < t0 + DEB + 50) at(cyc + 1);
    check(32'(rst_out), 32'h0);
    check(32'(cyc - t0 >= DEB), 32'h1);
    at(cyc + 2);
    check(32'(en[7]), 32'h0);
    wait_en(6, 1'b0, STEP * 9 + 100);
    t0 = cyc;
    for (int k = 7; k >= 1; k--) begin
      at(t0 + STEP * (7 - k));
      check(32'(en & 8'h6f), 32'(dn_exp(`SLOT_DEF_A, k)));
      at(t0 + STEP * (8 - k) - 1);
      check(32'(en & 8'h6f), 32'(dn_exp(`SLOT_DEF_A, k)));
    end
    at(t0 + STEP * 7 + 10);
    check(32'(en), 32'h0);
    apb(1'b0, `ADDR_VOLT, 32'h0);
    check(rd, `VOLT_DEF_A);
    apb(1'b0, `ADDR_LEVEL, 32'h0);
    check(rd, 32'h0);
    check(32'(irq), 32'h1);
    // Restart, then over-temperature trip
    @(posedge clk);
    on <= 1'b1;
    wait_en(0, 1'b1, DEB + STEP + 100);
    hot <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(32'(en), 32'h0);
    check(32'(rst_out), 32'h0);
    repeat (100) @(posedge clk);
    #1;
    check(32'(en), 32'h0);
    // Second reset in module setup: bias wait, then first step
    @(posedge clk);
    rst_n <= 1'b0;
    hot <= 1'b0;
    on <= 1'b0;
    topo <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    on <= 1'b1;
    t0 = cyc;
    at(t0 + `BIAS_CYCLES - 50);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(32'(rd[8:4]), 32'h2);
    at(t0 + `BIAS_CYCLES + 50);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(32'(rd[8:4]), 32'h3);
    wait_en(0, 1'b1, STEP + 100);
    check(32'(cyc - t0 >= `BIAS_CYCLES + STEP), 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
